// ==== rd_recv_defines.svh ====
// constants and behaviour notes for the read data receiver
// Notes on behaviour
// - every beat carries a read ID whose width is a build parameter, passed through unchanged.
// - a user sideband of configurable width is taken with every beat and kept with it.
// - the trace bit is taken only when the interface is built for AXI5 or ACE-Lite.
// - a loop field is taken with every beat alongside the rest of the response.
// - the unique-ID indicator is active high and travels with each beat.
// - chunk number and chunk strobe count only on beats with chunk-valid set, else ignored.
// - chunk strobe bit n qualifies data bits 128*n+127 down to 128*n.
// - the tag carries four bits per 128 data bits, at least four, nibble n for slice n.
`ifndef RD_RECV_DEFINES_SVH
`define RD_RECV_DEFINES_SVH
`define RD_FIFO_DEPTH 8
`define RD_DATA_W 128
`define RD_ID_W 8
`define RD_USER_W 4
`define RD_LOOP_W 2
`define RD_CNUM_W 8
`define RD_SLICE_W 128
`define RD_TAG_PER_SLICE 4
`define RD_RESP_W 4
`define RD_RESP_CODE_W 2
`define RD_BEATS_W 9
`endif

// ==== rd_recv_pkg.sv ====
// types shared by the read data receiver
`default_nettype none
package rd_recv_pkg;
  typedef enum logic [1:0] {
    resp_okay,
    resp_exokay,
    resp_slverr,
    resp_decerr
  } resp_e;
  typedef enum {
    txn_idle,
    txn_burst
  } txn_state_e;
endpackage
`default_nettype wire

// ==== beat_if.sv ====
// valid/ready carrier for packed read beats between the receiver and its fifo
`default_nettype none
interface beat_if #(parameter int W = 8) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== beat_fifo.sv ====
// parameterised fifo with a registered ready on the filling side
`default_nettype none
module beat_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // filling and draining sides
  beat_if.snk push,
  beat_if.src pop
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] level, next_level;
  logic in_rdy, next_in_rdy;
  logic push_fire, pop_fire;

  assign push_fire = push.valid && in_rdy;
  assign pop_fire = pop.valid && pop.ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_level = level;
    if (push_fire) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop_fire) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push_fire && !pop_fire) begin
      next_level = level + 1'b1;
    end else if (pop_fire && !push_fire) begin
      next_level = level - 1'b1;
    end
    // ready registered from the next fill level, so it never lies about room
    next_in_rdy = next_level < (AW + 1)'(DEPTH);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
      in_rdy <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      level <= next_level;
      in_rdy <= next_in_rdy;
    end
  end

  // storage has no reset: contents are only read behind a nonzero level
  always_ff @(posedge core_clk) begin
    if (push_fire) begin
      mem[wr_ptr] <= push.data;
    end
  end

  assign push.ready = in_rdy;
  assign pop.valid = (level != '0);
  assign pop.data = mem[rd_ptr];

  AST_FIFO_BOUND: assert property (@(posedge core_clk) disable iff (sys_rst)
    level <= (AW + 1)'(DEPTH)) else $error("fifo level above depth");
  AST_FIFO_FULL_STALL: assert property (@(posedge core_clk) disable iff (sys_rst)
    level == (AW + 1)'(DEPTH) |-> !push.ready) else $error("ready high while full");
endmodule // beat_fifo
`default_nettype wire

// ==== axi_read_data_receiver.sv ====
// read data channel receive side: slave beats through a fifo to the network side
`include "rd_recv_defines.svh"
`default_nettype none
module axi_read_data_receiver #(
  parameter int DATA_W = `RD_DATA_W,
  parameter int ID_W = `RD_ID_W,
  parameter int USER_W = `RD_USER_W,
  parameter int LOOP_W = `RD_LOOP_W,
  parameter int CNUM_W = `RD_CNUM_W,
  parameter int FIFO_DEPTH = `RD_FIFO_DEPTH,
  parameter bit AXI5_EN = 1'b1,
  localparam int SLICES = (DATA_W < `RD_SLICE_W) ? 1 : DATA_W / `RD_SLICE_W,
  localparam int TAG_W = `RD_TAG_PER_SLICE * SLICES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // read data channel from the slave
  input wire logic r_valid,
  output logic r_ready,
  input wire logic [ID_W-1:0] r_id,
  input wire logic [DATA_W-1:0] r_data,
  input wire logic [`RD_RESP_W-1:0] r_resp,
  input wire logic r_last,
  input wire logic [USER_W-1:0] r_user,
  input wire logic r_trace,
  input wire logic [LOOP_W-1:0] r_loop,
  input wire logic r_idunq,
  input wire logic r_chunk_valid,
  input wire logic [CNUM_W-1:0] r_chunk_num,
  input wire logic [SLICES-1:0] r_chunk_strb,
  input wire logic [TAG_W-1:0] r_tag,
  // beats toward the network
  output logic out_valid,
  input wire logic out_ready,
  output logic [ID_W-1:0] out_id,
  output logic [DATA_W-1:0] out_data,
  output logic [`RD_RESP_W-1:0] out_resp,
  output logic out_last,
  output logic [USER_W-1:0] out_user,
  output logic out_trace,
  output logic [LOOP_W-1:0] out_loop,
  output logic out_idunq,
  output logic out_chunk_valid,
  output logic [CNUM_W-1:0] out_chunk_num,
  output logic [SLICES-1:0] out_chunk_strb,
  output logic [SLICES-1:0] out_slice_mask,
  output logic [TAG_W-1:0] out_tag,
  // transaction status
  output logic txn_done,
  output logic txn_error,
  output logic [`RD_BEATS_W-1:0] txn_beats
);
  import rd_recv_pkg::*;

  localparam int PW = ID_W + DATA_W + `RD_RESP_W + 1 + USER_W + 1 + LOOP_W + 1 + 1
    + CNUM_W + SLICES + TAG_W;

  ////////////////////////////////////////////////////////////////////////////
  // packing and fifo

  beat_if #(.W(PW)) in_if ();
  beat_if #(.W(PW)) fifo_if ();

  logic [CNUM_W-1:0] in_cnum;
  logic [SLICES-1:0] in_cstrb;
  logic in_trace;

  // chunk fields cleared when chunk-valid is low, so stale values never leak
  assign in_cnum = r_chunk_valid ? r_chunk_num : '0;
  assign in_cstrb = r_chunk_valid ? r_chunk_strb : '0;
  // trace only exists on AXI5 / ACE-Lite builds
  assign in_trace = AXI5_EN ? r_trace : 1'b0;

  // ready is a flop, so the slave sees room one edge late; the fifo depth absorbs it
  assign in_if.valid = r_valid;
  assign in_if.data = {r_id, r_data, r_resp, r_last, r_user, in_trace, r_loop, r_idunq,
    r_chunk_valid, in_cnum, in_cstrb, r_tag};
  assign r_ready = in_if.ready;

  beat_fifo #(.W(PW), .DEPTH(FIFO_DEPTH)) u_beat_fifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .push(in_if.snk),
    .pop(fifo_if.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // output stage

  logic [ID_W-1:0] pop_id;
  logic [DATA_W-1:0] pop_data;
  logic [`RD_RESP_W-1:0] pop_resp;
  logic pop_last, pop_trace, pop_idunq, pop_cv;
  logic [USER_W-1:0] pop_user;
  logic [LOOP_W-1:0] pop_loop;
  logic [CNUM_W-1:0] pop_cnum;
  logic [SLICES-1:0] pop_cstrb;
  logic [TAG_W-1:0] pop_tag;
  logic pop_fire, out_fire;

  assign {pop_id, pop_data, pop_resp, pop_last, pop_user, pop_trace, pop_loop, pop_idunq,
    pop_cv, pop_cnum, pop_cstrb, pop_tag} = fifo_if.data;

  // one stage of hold: refill in the same cycle the network takes a beat
  assign fifo_if.ready = !out_valid || out_ready;
  assign pop_fire = fifo_if.valid && fifo_if.ready;
  assign out_fire = out_valid && out_ready;
  // payload regs load only on a pop, so a stalled beat cannot change under the network

  logic next_out_valid;

  always_comb begin
    next_out_valid = out_valid;
    if (pop_fire) begin
      next_out_valid = 1'b1;
    end else if (out_fire) begin
      next_out_valid = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
      out_id <= '0;
      out_data <= '0;
      out_resp <= '0;
      out_last <= 1'b0;
      out_user <= '0;
      out_trace <= 1'b0;
      out_loop <= '0;
      out_idunq <= 1'b0;
      out_chunk_valid <= 1'b0;
      out_chunk_num <= '0;
      out_chunk_strb <= '0;
      out_slice_mask <= '0;
      out_tag <= '0;
    end else begin
      out_valid <= next_out_valid;
      if (pop_fire) begin
        out_id <= pop_id;
        out_data <= pop_data;
        out_resp <= pop_resp;
        out_last <= pop_last;
        out_user <= pop_user;
        out_trace <= pop_trace;
        out_loop <= pop_loop;
        out_idunq <= pop_idunq;
        out_chunk_valid <= pop_cv;
        out_chunk_num <= pop_cnum;
        out_chunk_strb <= pop_cstrb;
        // bit n of the mask covers data slice n; unchunked beats are whole
        out_slice_mask <= pop_cv ? pop_cstrb : '1;
        out_tag <= pop_tag;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transaction tracking on the network hand-off

  txn_state_e state, next_state;
  logic [`RD_BEATS_W-1:0] beats, next_beats, next_txn_beats;
  logic err_acc, next_err_acc, next_txn_done, next_txn_error, beat_err;

  // slverr and decerr both carry the high code bit
  assign beat_err = out_resp[1];

  always_comb begin
    next_state = state;
    next_beats = beats;
    next_err_acc = err_acc;
    next_txn_done = 1'b0;
    next_txn_error = txn_error;
    next_txn_beats = txn_beats;
    case (state)
      txn_idle, txn_burst: begin
        if (out_fire) begin
          if (out_last) begin
            // the slave's last flag is the only end marker we have
            next_state = txn_idle;
            next_txn_done = 1'b1;
            next_txn_beats = beats + 1'b1;
            next_txn_error = err_acc || beat_err;
            next_beats = '0;
            next_err_acc = 1'b0;
          end else begin
            next_state = txn_burst;
            next_beats = beats + 1'b1;
            next_err_acc = err_acc || beat_err;
          end
        end
      end
      default: begin
        next_state = txn_idle;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= txn_idle;
      beats <= '0;
      err_acc <= 1'b0;
      txn_done <= 1'b0;
      txn_error <= 1'b0;
      txn_beats <= '0;
    end else begin
      state <= next_state;
      beats <= next_beats;
      err_acc <= next_err_acc;
      txn_done <= next_txn_done;
      txn_error <= next_txn_error;
      txn_beats <= next_txn_beats;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic in_fire, path_start;
  assign in_fire = r_valid && r_ready;
  // beat into an empty receiver reaches the output two edges later
  assign path_start = in_fire && !fifo_if.valid && !out_valid;

  AST_OUT_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
    out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_id))
    else $error("output beat changed while stalled");
  AST_ID_PATH: assert property (@(posedge core_clk) disable iff (sys_rst)
    path_start |-> ##2 out_valid && out_id == $past(r_id, 2))
    else $error("read id not carried to output");
  AST_USER_PATH: assert property (@(posedge core_clk) disable iff (sys_rst)
    path_start |-> ##2 out_user == $past(r_user, 2))
    else $error("user field not carried");
  AST_LOOP_PATH: assert property (@(posedge core_clk) disable iff (sys_rst)
    path_start |-> ##2 out_loop == $past(r_loop, 2))
    else $error("loop field not carried");
  AST_IDUNQ_PATH: assert property (@(posedge core_clk) disable iff (sys_rst)
    path_start |-> ##2 out_idunq == $past(r_idunq, 2))
    else $error("unique id flag not carried");
  AST_TAG_PATH: assert property (@(posedge core_clk) disable iff (sys_rst)
    path_start |-> ##2 out_tag == $past(r_tag, 2) && out_data == $past(r_data, 2))
    else $error("tag or data not carried");
  AST_TRACE_GATE: assert property (@(posedge core_clk) disable iff (sys_rst)
    path_start |-> ##2 out_trace == (AXI5_EN && $past(r_trace, 2)))
    else $error("trace bit wrong for build");
  AST_CHUNK_IGNORED: assert property (@(posedge core_clk) disable iff (sys_rst)
    out_valid && !out_chunk_valid |-> out_chunk_num == '0 && out_chunk_strb == '0
    && out_slice_mask == '1) else $error("chunk fields leak on unchunked beat");
  AST_SLICE_MASK: assert property (@(posedge core_clk) disable iff (sys_rst)
    out_valid && out_chunk_valid |-> out_slice_mask == out_chunk_strb)
    else $error("slice mask differs from chunk strobe");

  // one pulse per closed transaction, back to back single beats included
  AST_DONE_ON_LAST: assert property (@(posedge core_clk) disable iff (sys_rst)
    out_fire && out_last |=> txn_done)
    else $error("last beat did not close transaction");
  AST_DONE_ONLY_ON_LAST: assert property (@(posedge core_clk) disable iff (sys_rst)
    !(out_fire && out_last) |=> !txn_done)
    else $error("transaction closed without a last beat");
  AST_BEAT_COUNT: assert property (@(posedge core_clk) disable iff (sys_rst)
    out_fire && out_last |=> txn_beats == $past(beats) + 1'b1)
    else $error("beat count of closed transaction wrong");
  AST_ERR_FLAG: assert property (@(posedge core_clk) disable iff (sys_rst)
    out_fire && out_last && beat_err |=> txn_error)
    else $error("error response lost at close");
  AST_ERR_CLEAN: assert property (@(posedge core_clk) disable iff (sys_rst)
    out_fire && out_last && !beat_err && !err_acc |=> !txn_error)
    else $error("clean transaction flagged as error");
  AST_LAST_PATH: assert property (@(posedge core_clk) disable iff (sys_rst)
    path_start |-> ##2 out_last == $past(r_last, 2) && out_resp == $past(r_resp, 2))
    else $error("last flag or response not carried");
  AST_CHUNK_PATH: assert property (@(posedge core_clk) disable iff (sys_rst)
    path_start && r_chunk_valid |-> ##2 out_chunk_valid
    && out_chunk_num == $past(r_chunk_num, 2) && out_slice_mask == $past(r_chunk_strb, 2))
    else $error("chunk fields not carried");
  AST_CHUNK_CLEAR: assert property (@(posedge core_clk) disable iff (sys_rst)
    path_start && !r_chunk_valid |-> ##2 !out_chunk_valid && out_chunk_num == '0
    && out_chunk_strb == '0) else $error("chunk fields kept on unchunked beat");
  AST_TRACE_OFF: assert property (@(posedge core_clk) disable iff (sys_rst)
    !AXI5_EN |-> !out_trace)
    else $error("trace bit seen on a build without trace");
  // ready returns one edge after room appears: the price of a registered ready
  AST_READY_AFTER_POP: assert property (@(posedge core_clk) disable iff (sys_rst)
    !r_ready && pop_fire |=> r_ready)
    else $error("ready not restored after a pop");
  AST_OUT_FROM_FIFO: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(out_valid) |-> $past(fifo_if.valid))
    else $error("output beat without a buffered beat");

  // covers: bursts, chunked return, back-pressure both ways, error closes
  COV_FULL: cover property (@(posedge core_clk) disable iff (sys_rst)
    !r_ready && out_valid && !out_ready);
  COV_BURST: cover property (@(posedge core_clk) disable iff (sys_rst)
    out_fire && !out_last ##1 out_fire && out_last);
  COV_CHUNKED: cover property (@(posedge core_clk) disable iff (sys_rst)
    out_fire && out_chunk_valid);
  COV_STALL: cover property (@(posedge core_clk) disable iff (sys_rst)
    r_valid && !r_ready);
  COV_ERROR: cover property (@(posedge core_clk) disable iff (sys_rst)
    txn_done && txn_error);
endmodule // axi_read_data_receiver
`default_nettype wire

// ==== rd_slave_model.sv ====
// behavioural slave that feeds read beats to the receiver
`default_nettype none
module rd_slave_model #(
  parameter int BW = 296
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // read data channel
  input wire logic r_ready,
  input wire logic slow,
  output logic r_valid,
  output logic [BW-1:0] beat
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [BW-1:0] q[$];
  logic took;
  initial begin
    r_valid = 1'b0;
    beat = '0;
    took = 1'b0;
  end
  task automatic push(input logic [BW-1:0] b);
    q.push_back(b);
  endtask
  always @(posedge core_clk) begin
    took <= r_valid && r_ready;
  end
  // idle lines toggle so a stale beat never reads as data
  always @(negedge core_clk) begin
    if (sys_rst) begin
      r_valid <= 1'b0;
    end else if (!r_valid || took) begin
      if (q.size() > 0 && !(slow && r_valid)) begin
        beat <= q.pop_front();
        r_valid <= 1'b1;
      end else begin
        r_valid <= 1'b0;
        beat <= ~beat;
      end
    end
  end
endmodule // rd_slave_model
`default_nettype wire

// ==== tb_axi_read_data_receiver.sv ====
// self-checking bench for the read data receiver
`default_nettype none
module tb_axi_read_data_receiver;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BW = 296;
  localparam int EW = BW + 2;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic out_ready = 1'b0;
  logic slow = 1'b0;
  logic r_valid, r_ready, r_last, r_trace, r_idunq, r_chunk_valid;
  logic out_valid, out_last, out_trace, out_idunq, out_chunk_valid, txn_done, txn_error;
  logic [7:0] r_id, out_id, r_chunk_num, out_chunk_num, r_tag, out_tag;
  logic [255:0] r_data, out_data;
  logic [3:0] r_resp, out_resp, r_user, out_user;
  logic [1:0] r_loop, out_loop, r_chunk_strb, out_chunk_strb, out_slice_mask;
  logic [8:0] txn_beats;
  logic [BW-1:0] beat;
  logic [EW-1:0] exq[$];
  logic [9:0] tq[$];
  logic pend = 1'b0;
  logic hung = 1'b0;
  logic nt_trace;
  int checks = 0;
  int mismatches = 0;
  always #20 core_clk = ~core_clk;
  assign {r_id, r_data, r_resp, r_last, r_user, r_trace, r_loop, r_idunq, r_chunk_valid,
    r_chunk_num, r_chunk_strb, r_tag} = beat;
  axi_read_data_receiver #(.DATA_W(256)) u_axi_read_data_receiver (
    .core_clk, .sys_rst, .r_valid, .r_ready, .r_id, .r_data, .r_resp, .r_last, .r_user,
    .r_trace, .r_loop, .r_idunq, .r_chunk_valid, .r_chunk_num, .r_chunk_strb, .r_tag,
    .out_valid, .out_ready, .out_id, .out_data, .out_resp, .out_last, .out_user, .out_trace,
    .out_loop, .out_idunq, .out_chunk_valid, .out_chunk_num, .out_chunk_strb,
    .out_slice_mask, .out_tag, .txn_done, .txn_error, .txn_beats);
  rd_slave_model #(.BW(BW)) u_rd_slave_model (
    .core_clk, .sys_rst, .r_ready, .slow, .r_valid, .beat);
  // second build without trace sees the same stream; only its trace output is judged
  axi_read_data_receiver #(.DATA_W(256), .AXI5_EN(1'b0)) u_axi_read_data_receiver_nt (
    .core_clk, .sys_rst, .r_valid, .r_ready(), .r_id, .r_data, .r_resp, .r_last, .r_user,
    .r_trace, .r_loop, .r_idunq, .r_chunk_valid, .r_chunk_num, .r_chunk_strb, .r_tag,
    .out_valid(), .out_ready, .out_id(), .out_data(), .out_resp(), .out_last(), .out_user(),
    .out_trace(nt_trace), .out_loop(), .out_idunq(), .out_chunk_valid(), .out_chunk_num(),
    .out_chunk_strb(), .out_slice_mask(), .out_tag(), .txn_done(), .txn_error(),
    .txn_beats());
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [EW-1:0] seen, input logic [EW-1:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // chunk fields are junk when chunk-valid is low, so the receiver must clear them
  task automatic send(input logic [7:0] id, input int n, input logic cv, input logic [1:0] rc);
    logic [277:0] hd;
    logic [7:0] k;
    logic [1:0] st;
    logic [7:0] tg;
    for (int i = 0; i < n; i++) begin
      k = 8'(i);
      st = 2'(i + 1);
      tg = {k[3:0], ~k[3:0]};
      hd = {id, {32{id ^ k}}, 2'b10, (i == n - 1) ? rc : 2'b00, i == n - 1, k[3:0], k[0],
        k[1:0], id[0], cv};
      u_rd_slave_model.push({hd, cv ? k : ~k, cv ? st : ~st, tg});
      exq.push_back({hd, cv ? k : 8'h00, cv ? st : 2'b00, tg, cv ? st : 2'b11});
    end
    tq.push_back({9'(n), rc[1]});
  endtask
  task automatic wait_empty();
    for (int i = 0; i < 400 && exq.size() > 0; i++) @(negedge core_clk);
    if (exq.size() > 0) begin
      mismatches++;
      hung = 1'b1;
    end
    repeat (3) @(negedge core_clk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    if (pend) check(EW'({txn_done, txn_beats, txn_error}), EW'({1'b1, tq.pop_front()}));
    else if (!sys_rst) check(EW'(txn_done), '0);
    pend = out_valid && out_ready && out_last;
    if (out_valid && out_ready) begin
      check({out_id, out_data, out_resp, out_last, out_user, out_trace, out_loop, out_idunq,
        out_chunk_valid, out_chunk_num, out_chunk_strb, out_tag, out_slice_mask},
        exq.pop_front());
      check(EW'(nt_trace), '0);
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic sc_burst();
    out_ready = 1'b1;
    for (int rc = 0; rc < 4; rc++) send(8'h10 + 8'(rc), 2 + rc, 1'b0, 2'(rc));
    wait_empty();
  endtask
  task automatic sc_chunk();
    slow = 1'b1;
    send(8'h3c, 4, 1'b1, 2'd2);
    send(8'h3d, 1, 1'b1, 2'd0);
    wait_empty();
  endtask
  // nine beats fit inside, the tenth must be held on the wires
  task automatic sc_full();
    out_ready = 1'b0;
    slow = 1'b0;
    send(8'h55, 12, 1'b0, 2'd3);
    repeat (30) @(negedge core_clk);
    check(EW'(r_ready), '0);
    check(EW'(u_rd_slave_model.q.size()), EW'(2));
    out_ready = 1'b1;
    slow = 1'b1;
    wait_empty();
  endtask
  initial begin
    repeat (20) @(negedge core_clk);
    check(EW'({r_ready, out_valid}), '0);
    sys_rst = 1'b0;
    sc_burst();
    if (!hung) sc_chunk();
    if (!hung) sc_full();
    print_verdict();
  end
endmodule // tb_axi_read_data_receiver
`default_nettype wire
